// file: verilog/i2c_pkg.sv
// Function
// RQ1: START is SDA falling while SCL is high; the bus then counts as busy.
// RQ2: STOP is SDA rising while SCL is high; the bus then counts as free.
// RQ3: A RESTART issued instead of STOP keeps the bus busy.
// RQ4: RESTART is generated exactly like START.
// RQ5: Only the master role exists; no slave role can be selected.
// RQ6: The master drives SCL and sequences every transfer.
// RQ7: The receiver of each byte drives its acknowledge bit.
// RQ8: Each transfer starts with START, address and direction; the slave acknowledges.
// RQ9: Writes move byte by byte until the master sends STOP.
// RQ10: Master reader acknowledges bytes, NACKs the last, then STOP or RESTART. The code ACKs it if enable is low while a same-address read waits.
// RQ11: SDA changes only while SCL is low, except START, STOP, RESTART.
// RQ12: Pins only pull low or release, forming a wired-AND.
// RQ13: A queued command makes the master issue START.
// RQ14: An empty command queue makes the master issue STOP.
// RQ15: Slave clock stretching for read data does not apply here.
// RQ16: Combined read/write transfers work with 7-bit and 10-bit addresses.
// RQ17: A combined transfer never switches between 7-bit and 10-bit addressing.
// RQ18: With restart enabled, the next queued command follows directly.
// RQ19: A changed direction is issued as a combined transfer with RESTART.
// RQ20: Empty queue at transfer end gives STOP; the next transfer starts afresh.
// RQ21: Idle bus has SCL and SDA released.
// RQ22: 7-bit first byte is address in 7:1, direction in bit 0.
// RQ23: 10-bit first byte is marker, address 9:8, direction; second byte address 7:0.
// RQ24: A missing acknowledge makes the master abandon with STOP.
package i2c_pkg;
  localparam int unsigned LINK_PERIOD_NS = 80;
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned QUARTER_CYCLES = SCL_PERIOD_NS / (4 * LINK_PERIOD_NS);
  localparam int unsigned QCNT_W = 6;
  localparam logic [QCNT_W-1:0] QUARTER_LAST = QCNT_W'(QUARTER_CYCLES - 1);
  localparam logic [4:0] TEN_BIT_MARKER = 5'h1E;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_START = 2'b01,
    S_BYTE = 2'b10,
    S_STOP = 2'b11
  } link_state_t;

  typedef enum logic [1:0] {
    PH_HDR1 = 2'b00,
    PH_HDR2 = 2'b01,
    PH_WR = 2'b10,
    PH_RD = 2'b11
  } phase_t;

  typedef struct packed {
    logic ten_bit;
    logic [9:0] addr;
    logic read;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oen;
    logic sda_o;
    logic sda_oen;
  } pad_t;

  localparam pad_t PAD_RELEASED = '{scl_o: 1'b0, scl_oen: 1'b1, sda_o: 1'b0, sda_oen: 1'b1};

  function automatic logic [7:0] hdr_first(input logic ten, input logic [9:0] addr, input logic rd);
    hdr_first = ten ? {TEN_BIT_MARKER, addr[9:8], rd} : {addr[6:0], rd};
  endfunction
endpackage

// file: verilog/i2c_master_protocol_engine.sv
`timescale 1ns/1ps
module i2c_master_protocol_engine (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic enable,
  input wire logic restart_en,
  input wire logic cmd_valid,
  input wire i2c_pkg::cmd_t cmd,
  output logic cmd_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic abort,
  output logic bus_busy,
  output i2c_pkg::pad_t pads,
  input wire logic scl_i,
  input wire logic sda_i
);

  // Core domain: command hand-off and returned events.
  logic cmd_ready_q;
  logic req_tgl_q;
  i2c_pkg::cmd_t cmd_hold_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_s3_q;
  logic ab_s1_q;
  logic ab_s2_q;
  logic ab_s3_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic rx_valid_q;
  logic [7:0] rx_data_q;
  logic abort_q;
  logic bus_busy_q;

  // Link domain.
  logic lrst_s1_q;
  logic lrst_n;
  logic req_s1_q;
  logic req_s2_q;
  logic en_s1_q;
  logic en_s2_q;
  logic rs_s1_q;
  logic rs_s2_q;
  logic scl_s1_q;
  logic scl_s2_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic [i2c_pkg::QCNT_W-1:0] cnt_q;
  i2c_pkg::link_state_t state_q;
  i2c_pkg::phase_t phase_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic [7:0] rx_q;
  logic [7:0] rx_byte_q;
  logic rd_q;
  logic ten_q;
  logic [9:0] addr_q;
  logic again_q;
  logic nacked_q;
  logic busy_q;
  logic taken_q;
  logic rx_tgl_q;
  logic abort_tgl_q;
  i2c_pkg::pad_t pads_q;

  logic pend;
  logic hold;
  logic tick;
  logic more_rd;
  logic bit_out;
  logic ack_ok;
  logic same_slot;

  assign cmd_ready = cmd_ready_q;
  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
  assign abort = abort_q;
  assign bus_busy = bus_busy_q;
  assign pads = pads_q;

  // The word in cmd_hold_q stays still until the link side has toggled its taken flag back.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ready_q <= 1'b1;
      req_tgl_q <= 1'b0;
      cmd_hold_q <= '0;
    end else if (cmd_valid && cmd_ready_q) begin
      cmd_hold_q <= cmd;
      req_tgl_q <= ~req_tgl_q;
      cmd_ready_q <= 1'b0;
    end else if (!cmd_ready_q && (ack_s2_q == req_tgl_q)) begin
      cmd_ready_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      bus_busy_q <= 1'b0;
    end else begin
      ack_s1_q <= taken_q;
      ack_s2_q <= ack_s1_q;
      busy_s1_q <= busy_q;
      busy_s2_q <= busy_s1_q;
      bus_busy_q <= busy_s2_q;
    end
  end

  // Received bytes: the link register is stable for a whole bit time after its toggle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_data_q <= 8'h00;
    end else begin
      rx_s1_q <= rx_tgl_q;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      rx_valid_q <= rx_s2_q ^ rx_s3_q;
      if (rx_s2_q ^ rx_s3_q) begin
        rx_data_q <= rx_byte_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ab_s1_q <= 1'b0;
      ab_s2_q <= 1'b0;
      ab_s3_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      ab_s1_q <= abort_tgl_q;
      ab_s2_q <= ab_s1_q;
      ab_s3_q <= ab_s2_q;
      abort_q <= ab_s2_q ^ ab_s3_q;
    end
  end

  // Reset asserts at once in the link domain and releases on a link edge.
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lrst_s1_q <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_s1_q <= 1'b1;
      lrst_n <= lrst_s1_q;
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      rs_s1_q <= 1'b0;
      rs_s2_q <= 1'b0;
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      en_s1_q <= enable;
      en_s2_q <= en_s1_q;
      rs_s1_q <= restart_en;
      rs_s2_q <= rs_s1_q;
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
    end
  end

  assign pend = req_s2_q ^ taken_q;
  // A released SCL that still reads low is stretched by a slave; the quarter timer waits.
  assign hold = pads_q.scl_oen && !scl_s2_q && (state_q != i2c_pkg::S_IDLE);
  assign tick = (cnt_q == i2c_pkg::QUARTER_LAST) && !hold;
  assign more_rd = pend && cmd_hold_q.read && rd_q && (cmd_hold_q.addr == addr_q);
  assign bit_out = ((bit_q == i2c_pkg::ACK_BIT) && (phase_q == i2c_pkg::PH_RD)) ? !more_rd : shift_q[8];
  assign ack_ok = !sda_s2_q;
  assign same_slot = (cmd_hold_q.read == rd_q) && (cmd_hold_q.addr == addr_q) && !nacked_q;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      cnt_q <= '0;
    end else if (hold || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Sequencer: four quarters per bit, SDA moves in quarter 0 while SCL is low.
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      state_q <= i2c_pkg::S_IDLE;
      phase_q <= i2c_pkg::PH_HDR1;
      qtr_q <= 2'h0;
      bit_q <= 4'h0;
      shift_q <= 9'h1FF;
      rx_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rd_q <= 1'b0;
      ten_q <= 1'b0;
      addr_q <= 10'h000;
      again_q <= 1'b0;
      nacked_q <= 1'b0;
      busy_q <= 1'b0;
      taken_q <= 1'b0;
      rx_tgl_q <= 1'b0;
      abort_tgl_q <= 1'b0;
      pads_q <= i2c_pkg::PAD_RELEASED;
    end else if (tick) begin
      qtr_q <= qtr_q + 2'h1;
      case (state_q)
        i2c_pkg::S_IDLE: begin
          qtr_q <= 2'h0;
          pads_q <= i2c_pkg::PAD_RELEASED; // [RQ21] [RQ12]
          // Only a master sequence exists; SCL is never held waiting for slave read data. [RQ5] [RQ15]
          if (pend && en_s2_q) begin
            state_q <= i2c_pkg::S_START; // [RQ13]
            rd_q <= cmd_hold_q.read;
            ten_q <= cmd_hold_q.ten_bit;
            addr_q <= cmd_hold_q.addr;
            again_q <= 1'b0;
          end
        end
        i2c_pkg::S_START: begin
          case (qtr_q)
            2'h0: pads_q.sda_oen <= 1'b1;
            2'h1: pads_q.scl_oen <= 1'b1; // [RQ6]
            2'h2: begin
              pads_q.sda_oen <= 1'b0; // [RQ1] [RQ4]
              busy_q <= 1'b1; // [RQ3]
            end
            default: begin
              pads_q.scl_oen <= 1'b0;
              state_q <= i2c_pkg::S_BYTE;
              phase_q <= i2c_pkg::PH_HDR1;
              bit_q <= 4'h0;
              nacked_q <= 1'b0;
              // A 10-bit read first sends the header as a write, then repeats it. [RQ8] [RQ22] [RQ23]
              shift_q <= {i2c_pkg::hdr_first(ten_q, addr_q,
                (ten_q && !again_q) ? i2c_pkg::RW_WRITE : rd_q), 1'b1};
            end
          endcase
        end
        i2c_pkg::S_STOP: begin
          case (qtr_q)
            2'h0: pads_q.sda_oen <= 1'b0;
            2'h1: pads_q.scl_oen <= 1'b1;
            2'h2: begin
              pads_q.sda_oen <= 1'b1; // [RQ2]
              busy_q <= 1'b0;
            end
            default: state_q <= i2c_pkg::S_IDLE;
          endcase
        end
        default: begin
          case (qtr_q)
            2'h0: begin
              pads_q.sda_oen <= bit_out; // [RQ11] [RQ12]
              if ((bit_q == i2c_pkg::ACK_BIT) && (phase_q == i2c_pkg::PH_RD)) begin
                nacked_q <= bit_out; // [RQ7] [RQ10]
              end
            end
            2'h1: pads_q.scl_oen <= 1'b0;
            2'h2: pads_q.scl_oen <= 1'b1;
            default: begin
              pads_q.scl_oen <= 1'b0;
              rx_q <= {rx_q[6:0], sda_s2_q};
              shift_q <= {shift_q[7:0], 1'b1};
              bit_q <= bit_q + 4'h1;
              if (bit_q == i2c_pkg::ACK_BIT) begin
                bit_q <= 4'h0;
                if ((phase_q != i2c_pkg::PH_RD) && !ack_ok) begin
                  state_q <= i2c_pkg::S_STOP; // [RQ24]
                  abort_tgl_q <= ~abort_tgl_q;
                  // A refused address drops its command; otherwise the master would retry it forever.
                  if (phase_q != i2c_pkg::PH_WR) begin
                    taken_q <= ~taken_q; // [RQ24]
                  end
                end else begin
                  case (phase_q)
                    i2c_pkg::PH_HDR1: begin
                      if (ten_q && !again_q) begin
                        phase_q <= i2c_pkg::PH_HDR2;
                        shift_q <= {addr_q[7:0], 1'b1}; // [RQ23]
                      end else begin
                        taken_q <= ~taken_q;
                        phase_q <= cmd_hold_q.read ? i2c_pkg::PH_RD : i2c_pkg::PH_WR;
                        shift_q <= cmd_hold_q.read ? 9'h1FF : {cmd_hold_q.data, 1'b1};
                      end
                    end
                    i2c_pkg::PH_HDR2: begin
                      if (rd_q) begin
                        again_q <= 1'b1;
                        state_q <= i2c_pkg::S_START; // [RQ16]
                      end else begin
                        taken_q <= ~taken_q;
                        phase_q <= i2c_pkg::PH_WR;
                        shift_q <= {cmd_hold_q.data, 1'b1};
                      end
                    end
                    default: begin
                      if (phase_q == i2c_pkg::PH_RD) begin
                        rx_byte_q <= rx_q;
                        rx_tgl_q <= ~rx_tgl_q;
                      end
                      if (!pend || !en_s2_q) begin
                        state_q <= i2c_pkg::S_STOP; // [RQ14] [RQ20]
                      end else if (same_slot) begin
                        taken_q <= ~taken_q; // [RQ9]
                        phase_q <= cmd_hold_q.read ? i2c_pkg::PH_RD : i2c_pkg::PH_WR;
                        shift_q <= cmd_hold_q.read ? 9'h1FF : {cmd_hold_q.data, 1'b1};
                      end else if (rs_s2_q && (cmd_hold_q.ten_bit == ten_q)) begin
                        state_q <= i2c_pkg::S_START; // [RQ18] [RQ19] [RQ10]
                        rd_q <= cmd_hold_q.read;
                        addr_q <= cmd_hold_q.addr;
                        again_q <= 1'b0;
                      end else begin
                        // A change of address width is never combined; it closes the transfer first.
                        state_q <= i2c_pkg::S_STOP; // [RQ17] [RQ20]
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
      endcase
    end
  end

endmodule

// file: tb/i2c_master_protocol_engine_monitor.sv
`timescale 1ns/1ps
module i2c_master_protocol_engine_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic abort,
  input wire logic bus_busy,
  input wire i2c_pkg::pad_t pads,
  input wire logic scl_i
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_open_drain;
    !pads.scl_o && !pads.sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pad data not low");
  property p_start_busy;
    $fell(pads.sda_oen) && pads.scl_oen && scl_i |-> ##[1:8] bus_busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_stop_free;
    $rose(pads.sda_oen) && pads.scl_oen && scl_i |-> ##[1:10] !bus_busy;
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("stop without free");
  // Pads switch in the link domain; the idle check needs no delay, as SCL is released a quarter before busy_q clears.
  property p_idle_scl;
    !bus_busy |-> pads.scl_oen;
  endproperty
  a_idle_scl: assert property (p_idle_scl) else $error("clock held while idle");
  property p_take_start;
    cmd_valid && cmd_ready && enable && !bus_busy |-> ##[1:400] bus_busy;
  endproperty
  a_take_start: assert property (p_take_start) else $error("no start after command");
  property p_rx_pulse;
    rx_valid |=> !rx_valid;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx_valid too long");
  property p_rx_hold;
    !rx_valid |-> $stable(rx_data);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx_data moved");
  property p_abort_pulse;
    abort |=> !abort;
  endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort too long");
  property p_abort_stop;
    abort |-> ##[1:400] !bus_busy;
  endproperty
  a_abort_stop: assert property (p_abort_stop) else $error("abort without stop");
endmodule
bind i2c_master_protocol_engine i2c_master_protocol_engine_monitor i_mon (.core_clk(core_clk), .resetn(resetn),
  .enable(enable), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rx_valid(rx_valid), .rx_data(rx_data),
  .abort(abort), .bus_busy(bus_busy), .pads(pads), .scl_i(scl_i));

// file: tb/slave_model.sv
`timescale 1ns/1ps
module slave_model #(
  parameter logic [6:0] ADDR7 = 7'h50,
  parameter logic [1:0] ADDR10_HI = 2'h2,
  parameter logic [7:0] RD0 = 8'h3C
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oen
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rd_q = RD0;
  logic [7:0] log_q [0:31];
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic hdr = 1'b0;
  int bitn = 0;
  int n_bytes = 0;
  int n_starts = 0;
  int n_stops = 0;
  initial sda_oen = 1'b1;
  always @(negedge sda) begin
    if (scl) begin
      n_starts++;
      bitn = 0;
      hdr = 1'b1;
      rd = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      n_stops++;
      sel = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn++;
    end else begin
      if (!hdr && rd && sel) begin
        sel = !sda;
        rd_q++;
      end
      hdr = 1'b0;
      bitn = 0;
    end
  end
  // Driving only on the falling clock keeps data stable while the clock is high.
  always @(negedge scl) begin
    sda_oen = 1'b1;
    if (bitn == 8 && (hdr || !rd)) begin
      log_q[n_bytes] = sh;
      n_bytes++;
      if (hdr) begin
        sel = sh[7:1] == ADDR7 || (sh[7:3] == 5'h1E && sh[2:1] == ADDR10_HI);
        rd = sh[0];
      end
      sda_oen = !sel;
    end else if (bitn < 8 && rd && sel && !hdr) begin
      sda_oen = rd_q[7 - bitn];
    end
  end
endmodule

// file: tb/i2c_master_protocol_engine_tb.sv
`timescale 1ns/1ps
module i2c_master_protocol_engine_tb;
  localparam logic [7:0] RD0 = 8'h3C;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic restart_en = 1'b0;
  logic enable = 1'b1;
  logic cmd_valid = 1'b0;
  i2c_pkg::cmd_t cmd = '0;
  logic cmd_ready, rx_valid, abort, bus_busy, slv_oen, scl_line, sda_line;
  logic [7:0] rx_data;
  logic [7:0] rd_exp = RD0;
  logic [7:0] rx_log [0:31];
  i2c_pkg::pad_t pads;
  int miscompares = 0;
  int n_tests = 0;
  int n_rx = 0;
  int n_abort = 0;
  int b0, s0, p0, r0, a0;
  // Released lines float high through the pull-ups; the slave never stretches the clock.
  assign scl_line = pads.scl_oen;
  assign sda_line = pads.sda_oen & slv_oen;
  i2c_master_protocol_engine i_i2c_master_protocol_engine (.core_clk(core_clk), .resetn(resetn),
    .link_clk(link_clk), .enable(enable), .restart_en(restart_en), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rx_valid(rx_valid), .rx_data(rx_data), .abort(abort), .bus_busy(bus_busy),
    .pads(pads), .scl_i(scl_line), .sda_i(sda_line));
  slave_model #(.RD0(RD0)) i_slave_model (.scl(scl_line), .sda(sda_line), .sda_oen(slv_oen));
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #13 link_clk = 1'b1;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge core_clk) begin
    if (rx_valid) rx_log[n_rx] <= rx_data;
    n_rx <= n_rx + int'(rx_valid);
    n_abort <= n_abort + int'(abort);
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic send(input i2c_pkg::cmd_t c);
    int n;
    n = 0;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd = c;
    // Ready is judged at the falling edge, where it has settled; the next rising edge takes the word.
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    if (n >= 20000) check("cmd taken", 0, 1);
  endtask
  task automatic finish_xfer();
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    while (!(seen && bus_busy === 1'b0) && n < 30000) begin
      @(negedge core_clk);
      seen = seen | (bus_busy === 1'b1);
      n++;
    end
    if (n >= 30000) check("bus freed", 0, 1);
    repeat (100) @(negedge core_clk);
  endtask
  task automatic mark(input logic rs);
    restart_en = rs;
    b0 = i_slave_model.n_bytes;
    s0 = i_slave_model.n_starts;
    p0 = i_slave_model.n_stops;
    r0 = n_rx;
    a0 = n_abort;
  endtask
  task automatic check_bus(input string what, input int nb, input int ns, input int np);
    check({what, " bytes"}, i_slave_model.n_bytes - b0, nb);
    check({what, " starts"}, i_slave_model.n_starts - s0, ns);
    check({what, " stops"}, i_slave_model.n_stops - p0, np);
    check({what, " idle"}, {pads.scl_oen, pads.sda_oen, bus_busy}, 3'b110);
  endtask
  task automatic t_write7();
    mark(1'b0);
    send({1'b0, 10'h050, 1'b0, 8'hA5});
    send({1'b0, 10'h050, 1'b0, 8'h5A});
    finish_xfer();
    check_bus("wr7", 3, 1, 1);
    check("wr7 hdr", i_slave_model.log_q[b0], 8'hA0);
    check("wr7 d0", i_slave_model.log_q[b0 + 1], 8'hA5);
    check("wr7 d1", i_slave_model.log_q[b0 + 2], 8'h5A);
    $display("test write7 done");
  endtask
  task automatic t_read7();
    mark(1'b1);
    send({1'b0, 10'h050, 1'b1, 8'h00});
    send({1'b0, 10'h050, 1'b1, 8'h00});
    finish_xfer();
    check_bus("rd7", 1, 1, 1);
    check("rd7 hdr", i_slave_model.log_q[b0], 8'hA1);
    check("rd7 count", n_rx - r0, 2);
    check("rd7 b0", rx_log[r0], rd_exp);
    check("rd7 b1", rx_log[r0 + 1], rd_exp + 8'h01);
    check("rd7 abort", n_abort - a0, 0);
    rd_exp = rd_exp + 8'h02;
    $display("test read7 done");
  endtask
  task automatic t_combined();
    mark(1'b1);
    send({1'b0, 10'h050, 1'b0, 8'h11});
    send({1'b0, 10'h050, 1'b1, 8'h00});
    finish_xfer();
    check_bus("comb", 3, 2, 1);
    check("comb wr", i_slave_model.log_q[b0 + 1], 8'h11);
    check("comb hdr", i_slave_model.log_q[b0 + 2], 8'hA1);
    check("comb rd", rx_log[r0], rd_exp);
    rd_exp = rd_exp + 8'h01;
    $display("test combined done");
  endtask
  task automatic t_ten();
    mark(1'b1);
    send({1'b0, 10'h050, 1'b0, 8'h99});
    send({1'b1, 10'h2A5, 1'b0, 8'hC3});
    send({1'b1, 10'h2A5, 1'b1, 8'h00});
    finish_xfer();
    check("ten stops", i_slave_model.n_stops - p0, 2);
    check_bus("ten", 8, 4, 2);
    check("ten hdr", i_slave_model.log_q[b0 + 2], 8'hF4);
    check("ten lo", i_slave_model.log_q[b0 + 3], 8'hA5);
    check("ten wr", i_slave_model.log_q[b0 + 4], 8'hC3);
    check("ten rd", rx_log[r0], rd_exp);
    rd_exp = rd_exp + 8'h01;
    $display("test ten-bit done");
  endtask
  task automatic t_enable();
    mark(1'b0);
    enable = 1'b0;
    send({1'b0, 10'h050, 1'b0, 8'h3A});
    repeat (400) @(negedge core_clk);
    check("en held starts", i_slave_model.n_starts - s0, 0);
    check("en held busy", bus_busy, 0);
    enable = 1'b1;
    finish_xfer();
    check_bus("en", 2, 1, 1);
    check("en d0", i_slave_model.log_q[b0 + 1], 8'h3A);
    $display("test enable done");
  endtask
  task automatic t_nack();
    mark(1'b0);
    send({1'b0, 10'h011, 1'b0, 8'h77});
    finish_xfer();
    check_bus("nack", 1, 1, 1);
    check("nack hdr", i_slave_model.log_q[b0], 8'h22);
    check("nack abort", n_abort - a0, 1);
    check("nack dropped", cmd_ready, 1);
    $display("test nack done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    check("reset outputs", {cmd_ready, rx_valid, abort, bus_busy, pads, rx_data}, 16'h8500);
    resetn = 1'b1;
    repeat (10) @(negedge core_clk);
    t_write7();
    t_read7();
    t_combined();
    t_ten();
    t_enable();
    t_nack();
    complete_run();
  end
  // The tests need about 44000 cycles; the margin covers slow byte handoffs.
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end
endmodule
